// ---- src/cgm_regs.svh ----
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the design modules of the block and by the testbench
`ifndef CGM_REGS_SVH
`define CGM_REGS_SVH

`define CGM_OFS_CTRL1 8'h00
`define CGM_OFS_CTRL2 8'h04
`define CGM_OFS_STAT 8'h08
`define CGM_OFS_LOOP 8'h0c

`define CGM_CTRL1_RST 8'h04
`define CGM_CTRL2_RST 8'h40

`define CGM_F_CLKSRC_HI 7
`define CGM_F_CLKSRC_LO 6
`define CGM_F_REFERENCE_DIVIDER_HI 5
`define CGM_F_REFERENCE_DIVIDER_LO 3
`define CGM_F_IREFSEL 2
`define CGM_F_IRGATE 1
`define CGM_F_IRKEEP 0
`define CGM_F_BUS_DIVIDER_HI 7
`define CGM_F_BUS_DIVIDER_LO 6
`define CGM_F_RANGE 5
`define CGM_F_HGAIN 4
`define CGM_F_BYPPD 3
`define CGM_F_OSCREQ 2
`define CGM_F_ERGATE 1
`define CGM_F_ERKEEP 0
`define CGM_F_LOOPSEL 0
`define CGM_F_STOPREQ 1

`define CGM_SYNC_STAGES 2
`define CGM_HSIZE_WORD 3'h2
`define CGM_HTRANS_NONSEQ 2'h2
`define CGM_ADDR_BITS 8

`endif

// ---- src/cgm_pkg.sv ----
// types shared by the clock generator mode control block
// assumes cgm_regs.svh sits beside it on the include path
package cgm_pkg;
    typedef enum logic [1:0] {
        CGM_SRC_LOOP = 2'h0,
        CGM_SRC_IREF = 2'h1,
        CGM_SRC_EREF = 2'h2,
        CGM_SRC_RSVD = 2'h3
    } cgm_src_e;

    // nine modes, stop included
    typedef enum logic [3:0] {
        CGM_MODE_LOOP_ENG_INT = 4'h0,
        CGM_MODE_LOOP_ENG_EXT = 4'h1,
        CGM_MODE_LOOP_BYP_INT = 4'h2,
        CGM_MODE_LOOP_BYP_EXT = 4'h3,
        CGM_MODE_PLL_ENG_EXT = 4'h4,
        CGM_MODE_PLL_BYP_EXT = 4'h5,
        CGM_MODE_LP_BYP_INT = 4'h6,
        CGM_MODE_LP_BYP_EXT = 4'h7,
        CGM_MODE_STOP = 4'h8
    } cgm_mode_e;
endpackage : cgm_pkg

// ---- src/cgm_sync_if.sv ----
// carries select bits toward the status synchroniser and back
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface cgm_sync_if;
    logic [3:0] sel_raw;
    logic [3:0] sel_sync;
    modport ctrl (output sel_raw, input sel_sync);
    modport sync (input sel_raw, output sel_sync);
endinterface : cgm_sync_if

// ---- src/cgm_status_sync.sv ----
// two-stage synchroniser for the select status indications
// assumes i_mclk and i_rst_n of the control block
`timescale 1ns/1ps
`include "cgm_regs.svh"
module cgm_status_sync
    import cgm_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    cgm_sync_if.sync port
);
    logic [3:0] stage_q [`CGM_SYNC_STAGES];

    // status lags the write by the full chain, never same cycle
    generate
        for (genvar g = 0; g < `CGM_SYNC_STAGES; g++)
        begin : g_stage
            always_ff @(posedge i_mclk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    stage_q[g] <= 4'h1;
                else if (g == 0)
                    stage_q[g] <= port.sel_raw;
                else
                    stage_q[g] <= stage_q[(g > 0) ? g - 1 : 0];
            end
        end
    endgenerate

    assign port.sel_sync = stage_q[`CGM_SYNC_STAGES-1];
endmodule : cgm_status_sync

// ---- src/cgm_mode_ctrl.sv ----
// clock generator mode control with an AHB-Lite register slave
// assumes a single AHB-Lite master and on-chip clock consumers only
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "cgm_regs.svh"

// Summary of operation
// - nine modes: engaged, bypassed, low-power bypassed, pll variants, stop.
// - no signal leaves the chip; all ports are internal.
// - source field 00 loop, 01 internal ref, 10 external ref.
// - source code 11 behaves as loop output.
// - reference divider codes 0..3 divide 1..8, 6 and 7 divide 64, 128.
// - reference select 1 internal, 0 external.
// - internal ref output gate enables the internal reference output.
// - internal ref runs in stop if keep and gate or internal mode.
// - bus divider 1,2,4,8; resets to divide by 2.
// - range bit picks external high or low frequency range.
// - gain bit picks high gain or low power oscillator.
// - power-down bit stops the loop in bypassed modes.
// - oscillator request bit picks crystal or direct clock.
// - external ref output gate enables the external reference output.
// - external ref runs in stop if keep and gate or external mode.
// - status fields follow select writes only after synchronisation.
// - changing ref select, loop select or divider clears lock.
module cgm_mode_ctrl
    import cgm_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_loop_lock_det,
    output logic [1:0] o_system_clock_source_select,
    output logic [7:0] o_ref_divide_ratio,
    output logic o_internal_reference_select,
    output logic o_internal_reference_clock_out,
    output logic o_internal_ref_run,
    output logic [3:0] o_bus_divide_ratio,
    output logic o_external_high_range,
    output logic o_oscillator_high_gain,
    output logic o_external_source_oscillator_request,
    output logic o_external_reference_clock_out,
    output logic o_external_ref_run,
    output logic o_loop_type_select,
    output logic o_fll_enable,
    output logic o_pll_enable,
    output logic [3:0] o_mode,
    output logic o_lock
);
    ////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [1:0] loop_q;
    logic wr_pend_q;
    logic [`CGM_ADDR_BITS-1:0] wr_addr_q;
    logic lock_q;
    logic stop_q;
    cgm_mode_e mode_q;
    cgm_mode_e mode_d;
    cgm_mode_e run_mode_q;
    logic [3:0] pow2_sel;
    cgm_sync_if sif ();

    // no off-chip pins: every port is an on-chip net
    function automatic logic [7:0] pow2(input logic [2:0] code);
        pow2 = 8'h01 << code;
    endfunction : pow2

    function automatic logic is_int_mode(input cgm_mode_e m);
        is_int_mode = (m == CGM_MODE_LOOP_ENG_INT)
            || (m == CGM_MODE_LOOP_BYP_INT)
            || (m == CGM_MODE_LP_BYP_INT);
    endfunction : is_int_mode

    ////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY

    logic addr_ok;
    assign addr_ok = i_hsel && i_hready && i_htrans[1]
        && (i_hsize == `CGM_HSIZE_WORD);

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else if (i_hready)
        begin
            wr_pend_q <= addr_ok && i_hwrite;
            wr_addr_q <= i_haddr[`CGM_ADDR_BITS-1:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_hrdata <= 32'h0000_0000;
        else if (addr_ok && !i_hwrite)
        begin
            unique case (i_haddr[`CGM_ADDR_BITS-1:0])
                `CGM_OFS_CTRL1: o_hrdata <= {24'h000000, ctrl1_q};
                `CGM_OFS_CTRL2: o_hrdata <= {24'h000000, ctrl2_q};
                `CGM_OFS_STAT: o_hrdata <= {23'h000000, lock_q,
                    4'h0, sif.sel_sync};
                `CGM_OFS_LOOP: o_hrdata <= {30'h00000000, loop_q};
                default: o_hrdata <= 32'h0000_0000;
            endcase
        end
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    logic wr1;
    logic wr2;
    logic wrl;
    assign wr1 = wr_pend_q && (wr_addr_q == `CGM_OFS_CTRL1);
    assign wr2 = wr_pend_q && (wr_addr_q == `CGM_OFS_CTRL2);
    assign wrl = wr_pend_q && (wr_addr_q == `CGM_OFS_LOOP);

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ctrl1_q <= `CGM_CTRL1_RST; // divider resets to 000
        else if (wr1)
            ctrl1_q <= i_hwdata[7:0];
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ctrl2_q <= `CGM_CTRL2_RST; // bus divide by 2
        else if (wr2)
            ctrl2_q <= i_hwdata[7:0];
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            loop_q <= 2'h0;
        else if (wrl)
            loop_q <= i_hwdata[1:0];
    end

    ////////////////////////////////////////////////////////////////////
    // field decode

    logic [1:0] src_raw;
    cgm_src_e src;
    logic [2:0] reference_divider;
    logic iref_sel;
    logic byp_pd;
    logic pll_sel;
    assign src_raw = ctrl1_q[`CGM_F_CLKSRC_HI:`CGM_F_CLKSRC_LO];
    assign src = cgm_src_e'(src_raw == 2'h3 ? 2'h0 : src_raw);
    assign reference_divider = ctrl1_q[`CGM_F_REFERENCE_DIVIDER_HI:`CGM_F_REFERENCE_DIVIDER_LO];
    assign iref_sel = ctrl1_q[`CGM_F_IREFSEL];
    assign byp_pd = ctrl2_q[`CGM_F_BYPPD];
    assign pll_sel = loop_q[`CGM_F_LOOPSEL];
    assign stop_q = loop_q[`CGM_F_STOPREQ];

    // divided reference range is software's duty, not checked
    // codes 4,5 continue the power-of-two run
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_ref_divide_ratio <= 8'h01;
        else
            o_ref_divide_ratio <= pow2(reference_divider);
    end

    assign pow2_sel = 4'h1 << ctrl2_q[`CGM_F_BUS_DIVIDER_HI:`CGM_F_BUS_DIVIDER_LO];

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_system_clock_source_select <= 2'h0;
            o_internal_reference_select <= 1'b1;
            o_bus_divide_ratio <= 4'h2;
            o_external_high_range <= 1'b0;
            o_oscillator_high_gain <= 1'b0;
            o_external_source_oscillator_request <= 1'b0;
            o_loop_type_select <= 1'b0;
        end
        else
        begin
            o_system_clock_source_select <= src;
            o_internal_reference_select <= iref_sel;
            o_bus_divide_ratio <= pow2_sel;
            o_external_high_range <= ctrl2_q[`CGM_F_RANGE];
            o_oscillator_high_gain <= ctrl2_q[`CGM_F_HGAIN];
            o_external_source_oscillator_request <=
                ctrl2_q[`CGM_F_OSCREQ];
            o_loop_type_select <= pll_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode tracking

    always_comb
    begin
        mode_d = CGM_MODE_LOOP_ENG_INT;
        if (stop_q)
            mode_d = CGM_MODE_STOP;
        else
        begin
            unique case (src)
                CGM_SRC_LOOP:
                    mode_d = pll_sel ? CGM_MODE_PLL_ENG_EXT
                        : (iref_sel ? CGM_MODE_LOOP_ENG_INT
                        : CGM_MODE_LOOP_ENG_EXT);
                CGM_SRC_IREF:
                    mode_d = byp_pd ? CGM_MODE_LP_BYP_INT
                        : CGM_MODE_LOOP_BYP_INT;
                default:
                    mode_d = byp_pd ? CGM_MODE_LP_BYP_EXT
                        : (pll_sel ? CGM_MODE_PLL_BYP_EXT
                        : CGM_MODE_LOOP_BYP_EXT);
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            mode_q <= CGM_MODE_LOOP_ENG_INT;
        else
            mode_q <= mode_d;
    end

    // mode last held before stop decides what keeps running
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            run_mode_q <= CGM_MODE_LOOP_ENG_INT;
        else if (mode_q != CGM_MODE_STOP)
            run_mode_q <= mode_q;
    end

    assign o_mode = mode_q;

    ////////////////////////////////////////////////////////////////////
    // reference gating and loop enables

    logic in_stop;
    logic bypassed;
    logic loop_on;
    assign in_stop = (mode_q == CGM_MODE_STOP);
    assign bypassed = (src != CGM_SRC_LOOP);
    assign loop_on = !in_stop && !(bypassed && byp_pd);

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_internal_reference_clock_out <= 1'b0;
            o_external_reference_clock_out <= 1'b0;
            o_internal_ref_run <= 1'b1;
            o_external_ref_run <= 1'b0;
            o_fll_enable <= 1'b1;
            o_pll_enable <= 1'b0;
        end
        else
        begin
            o_internal_reference_clock_out <=
                ctrl1_q[`CGM_F_IRGATE] && !in_stop;
            o_external_reference_clock_out <=
                ctrl2_q[`CGM_F_ERGATE] && !in_stop;
            o_internal_ref_run <= in_stop
                ? (ctrl1_q[`CGM_F_IRKEEP] && (ctrl1_q[`CGM_F_IRGATE]
                    || is_int_mode(run_mode_q)))
                : (ctrl1_q[`CGM_F_IRGATE] || iref_sel
                    || src == CGM_SRC_IREF);
            o_external_ref_run <= in_stop
                ? (ctrl2_q[`CGM_F_ERKEEP] && (ctrl2_q[`CGM_F_ERGATE]
                    || !is_int_mode(run_mode_q)))
                : (ctrl2_q[`CGM_F_ERGATE] || !iref_sel
                    || src == CGM_SRC_EREF);
            o_fll_enable <= loop_on && !pll_sel;
            o_pll_enable <= loop_on && pll_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status synchroniser and lock indication

    assign sif.sel_raw = {src, pll_sel, iref_sel};

    cgm_status_sync u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .port(sif.sync)
    );

    logic lock_disturb;
    logic relock_q;
    assign lock_disturb = (wr1 && (i_hwdata[`CGM_F_IREFSEL] != iref_sel
            || i_hwdata[`CGM_F_REFERENCE_DIVIDER_HI:`CGM_F_REFERENCE_DIVIDER_LO] != reference_divider))
        || (wrl && i_hwdata[`CGM_F_LOOPSEL] != pll_sel)
        || in_stop || !loop_on;

    // detector lags the outputs: a stale high must fall before relock
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            relock_q <= 1'b0;
        else if (lock_disturb)
            relock_q <= 1'b1;
        else if (!i_loop_lock_det)
            relock_q <= 1'b0;
    end

    // clear wins here: detector must see a fresh settle first
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            lock_q <= 1'b0;
        else if (lock_disturb)
            lock_q <= 1'b0;
        else
            lock_q <= i_loop_lock_det && !relock_q;
    end

    assign o_lock = lock_q;
endmodule : cgm_mode_ctrl

// ---- verif/cgm_loop_model.sv ----
// lock detector stand-in for the loops fed by the mode control block
// assumes the block's clock and reset; only lock detect is modelled
`timescale 1ns/1ps
module cgm_loop_model #(
    parameter int LOCK_CYCLES = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_loop_on,
    input wire logic [9:0] i_ref_cfg,
    output logic o_lock_det
);
    logic [9:0] cfg_q;
    logic [7:0] cnt_q;
    // a changed reference slips lock in the same cycle, no grace period
    assign o_lock_det = i_loop_on && (i_ref_cfg == cfg_q)
        && (cnt_q == 8'(LOCK_CYCLES));
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_q <= 8'h00;
        else if (!i_loop_on || i_ref_cfg != cfg_q)
            cnt_q <= 8'h00;
        else if (cnt_q != 8'(LOCK_CYCLES))
            cnt_q <= cnt_q + 8'h01;
    end
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cfg_q <= 10'h000;
        else
            cfg_q <= i_ref_cfg;
    end
endmodule : cgm_loop_model

// ---- verif/cgm_mode_ctrl_properties.sv ----
// output relations of the clock generator mode control block
// assumes the bind below; one clock, active low async reset
`timescale 1ns/1ps
module cgm_mode_ctrl_properties
    import cgm_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic i_loop_lock_det,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic [1:0] o_system_clock_source_select,
    input wire logic [7:0] o_ref_divide_ratio,
    input wire logic [3:0] o_bus_divide_ratio,
    input wire logic o_internal_reference_clock_out,
    input wire logic o_external_reference_clock_out,
    input wire logic o_fll_enable,
    input wire logic o_pll_enable,
    input wire logic [3:0] o_mode,
    input wire logic o_lock
);
    logic rd_req;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////
    assign rd_req = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
    // held modes, so a one-cycle lag between outputs is tolerated
    sequence s_in_stop;
        (o_mode == CGM_MODE_STOP) [*3];
    endsequence
    sequence s_in_lp;
        (o_mode == CGM_MODE_LP_BYP_INT
            || o_mode == CGM_MODE_LP_BYP_EXT) [*3];
    endsequence
    a_bus_okay: assert property (o_hreadyout && !o_hresp)
        else $error("bus answer not ready or not okay");
    a_rdata_hold: assert property (!rd_req |=> $stable(o_hrdata))
        else $error("read data moved without a read");
    a_src_no_rsvd: assert property (
        o_system_clock_source_select != 2'h3)
        else $error("reserved source code reached the output");
    a_refdiv_hot: assert property ($onehot(o_ref_divide_ratio))
        else $error("reference divide ratio not one-hot");
    a_busdiv_hot: assert property ($onehot(o_bus_divide_ratio))
        else $error("bus divide ratio not one-hot");
    a_mode_legal: assert property (o_mode <= CGM_MODE_STOP)
        else $error("mode code out of range");
    a_stop_gates: assert property (s_in_stop |->
        !o_internal_reference_clock_out && !o_external_reference_clock_out)
        else $error("reference output active in stop");
    a_lp_loop_off: assert property (s_in_lp |->
        !o_fll_enable && !o_pll_enable)
        else $error("loop powered in low power bypass");
    a_pll_powered: assert property (
        (o_mode == CGM_MODE_PLL_ENG_EXT) [*3] |-> o_pll_enable)
        else $error("pll engaged without pll enable");
    a_lock_cause: assert property (
        $rose(o_lock) |-> $past(i_loop_lock_det))
        else $error("lock set without detector");
    a_lock_drop: assert property (
        $fell(i_loop_lock_det) |-> ##[0:3] !o_lock)
        else $error("lock kept after detector dropped");
endmodule : cgm_mode_ctrl_properties

bind cgm_mode_ctrl cgm_mode_ctrl_properties u_props (
    .i_mclk, .i_rst_n, .i_hsel, .i_htrans, .i_hwrite, .i_hready,
    .i_loop_lock_det, .o_hrdata, .o_hreadyout, .o_hresp,
    .o_system_clock_source_select, .o_ref_divide_ratio, .o_bus_divide_ratio,
    .o_internal_reference_clock_out, .o_external_reference_clock_out,
    .o_fll_enable, .o_pll_enable, .o_mode, .o_lock
);

// ---- verif/tb_clock_generator_mode_control.sv ----
// self-checking bench: register traffic over the bus, port checks
// assumes cgm_regs.svh on the include path and the loop model
`timescale 1ns/1ps
`include "cgm_regs.svh"
module tb_clock_generator_mode_control
    import cgm_pkg::*;
;
    logic i_mclk, i_rst_n, i_hsel, i_hwrite, i_loop_lock_det, o_hreadyout;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
    logic [1:0] i_htrans, o_system_clock_source_select;
    logic [2:0] i_hsize;
    logic [7:0] o_ref_divide_ratio, v1, v2;
    logic [3:0] o_bus_divide_ratio, o_mode;
    logic o_internal_reference_select, o_internal_reference_clock_out;
    logic o_internal_ref_run, o_external_high_range, o_oscillator_high_gain;
    logic o_external_source_oscillator_request, o_external_reference_clock_out;
    logic o_external_ref_run, o_loop_type_select, o_fll_enable, o_pll_enable;
    logic o_lock;
    int n_fail = 0;
    int compares = 0;
    // {ctrl1, ctrl2, mode, 0 fll irun erun}: mode before stop, runs in stop
    logic [23:0] st [7] = '{24'h050006, 24'h040104, 24'h450862,
        24'h800971, 24'h830036, 24'h040305, 24'h450026};
    cgm_mode_ctrl dut (
        .i_mclk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
        .i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout,
        .o_hresp(), .i_loop_lock_det, .o_system_clock_source_select,
        .o_ref_divide_ratio, .o_internal_reference_select,
        .o_internal_reference_clock_out, .o_internal_ref_run,
        .o_bus_divide_ratio, .o_external_high_range, .o_oscillator_high_gain,
        .o_external_source_oscillator_request,
        .o_external_reference_clock_out, .o_external_ref_run,
        .o_loop_type_select, .o_fll_enable, .o_pll_enable, .o_mode, .o_lock
    );
    cgm_loop_model u_loop (
        .i_mclk, .i_rst_n, .i_loop_on(o_fll_enable | o_pll_enable),
        .i_ref_cfg({o_ref_divide_ratio, o_internal_reference_select,
            o_loop_type_select}),
        .o_lock_det(i_loop_lock_det)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // every wait is bounded; a silent slave ends the run as a failure
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge i_mclk);
        while (o_hreadyout !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                n_fail++;
                final_report();
            end
            @(posedge i_mclk);
        end
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [31:0] r);
        @(posedge i_mclk);
        i_hsel <= 1'b1;
        i_htrans <= `CGM_HTRANS_NONSEQ;
        i_haddr <= {24'h000000, a};
        i_hwrite <= w;
        i_hsize <= `CGM_HSIZE_WORD;
        wait_rdy();
        i_htrans <= 2'h0;
        i_hwdata <= {24'h000000, d};
        wait_rdy();
        r = o_hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, rd);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 8'h00, rd);
        chk(rd, e);
    endtask : rd_chk
    // negedge sampling keeps checks clear of the launching edge
    task automatic idle(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : idle
    task automatic wait_lock();
        int n;
        n = 0;
        while (o_lock !== 1'b1)
        begin
            n++;
            if (n > 100)
            begin
                n_fail++;
                final_report();
            end
            @(negedge i_mclk);
        end
        compares++;
    endtask : wait_lock
    initial
    begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    initial
    begin
        i_rst_n = 1'b0;
        i_hsel = 1'b0;
        i_haddr = 32'h0;
        i_htrans = 2'h0;
        i_hwrite = 1'b0;
        i_hsize = 3'h0;
        i_hwdata = 32'h0;
        repeat (3) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        idle(2);
        chk(32'({o_bus_divide_ratio, o_ref_divide_ratio}),
            32'h201);
        chk(32'(o_mode), 32'(CGM_MODE_LOOP_ENG_INT));
        rd_chk(`CGM_OFS_CTRL1, 32'h04);
        rd_chk(`CGM_OFS_CTRL2, 32'h40);
        wr(8'h10, 8'hff);
        rd_chk(8'h10, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            wr(`CGM_OFS_CTRL1, 8'(i << 3) | 8'h04);
            idle(3);
            chk(32'(o_ref_divide_ratio), 32'h1 << i);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(`CGM_OFS_CTRL1, 8'(i << 6) | 8'h04);
            wr(`CGM_OFS_CTRL2, 8'(i << 6));
            idle(3);
            chk(32'(o_system_clock_source_select),
                32'((i == 3) ? 0 : i));
            chk(32'(o_bus_divide_ratio), 32'h1 << i);
        end
        for (int k = 0; k < 2; k++)
        begin
            v1 = k ? 8'h00 : 8'h06;
            v2 = k ? 8'h00 : 8'h36;
            wr(`CGM_OFS_CTRL1, v1);
            wr(`CGM_OFS_CTRL2, v2);
            idle(3);
            chk(32'({o_internal_reference_clock_out,
                o_internal_reference_select}),
                32'({v1[1], v1[2]}));
            chk(32'({o_external_high_range, o_oscillator_high_gain,
                o_external_source_oscillator_request,
                o_external_reference_clock_out}),
                32'({v2[5], v2[4], v2[2], v2[1]}));
            rd_chk(`CGM_OFS_CTRL2, 32'(v2));
        end
        wr(`CGM_OFS_CTRL1, 8'h80);
        xfer(1'b0, `CGM_OFS_STAT, 8'h00, rd);
        chk(32'(rd[3:2]), 32'h0);
        idle(6);
        xfer(1'b0, `CGM_OFS_STAT, 8'h00, rd);
        chk(32'(rd[3:2]), 32'h2);
        foreach (st[k])
        begin
            wr(`CGM_OFS_CTRL1, st[k][23:16]);
            wr(`CGM_OFS_CTRL2, st[k][15:8]);
            idle(3);
            chk(32'({o_mode, o_fll_enable}),
                32'({st[k][7:4], st[k][2]}));
            wr(`CGM_OFS_LOOP, 8'h02);
            idle(3);
            chk(32'({o_mode, o_internal_ref_run, o_external_ref_run}),
                32'({4'h8, st[k][1:0]}));
            wr(`CGM_OFS_LOOP, 8'h00);
        end
        wr(`CGM_OFS_CTRL1, 8'h00);
        wr(`CGM_OFS_CTRL2, 8'h00);
        wr(`CGM_OFS_LOOP, 8'h01);
        wait_lock();
        chk(32'({o_mode, o_pll_enable, o_loop_type_select}),
            32'({CGM_MODE_PLL_ENG_EXT, 2'h3}));
        rd_chk(`CGM_OFS_STAT, 32'h102);
        rd_chk(`CGM_OFS_LOOP, 32'h1);
        wr(`CGM_OFS_CTRL1, 8'h08);
        // every cycle: a stale detector must not bring lock back
        repeat (4)
        begin
            idle(1);
            chk(32'(o_lock), 32'h0);
        end
        wait_lock();
        wr(`CGM_OFS_CTRL1, 8'h80);
        idle(3);
        chk(32'({o_mode, o_pll_enable}),
            32'({CGM_MODE_PLL_BYP_EXT, 1'b1}));
        final_report();
    end
endmodule : tb_clock_generator_mode_control
